//--- rtl/rss_reset_supervisor.sv
// Reset sequencer, supply-drop reset and voltage warning detector.
// Assumes comparators give clean levels; the pin wire resolves pull-up outside.
`timescale 1ns/100ps

module rss_reset_supervisor
    import rss_pkg::*;
#(
    parameter int STRETCH = STRETCH_CYC, // Pin stretch length in cycles
    parameter int DLY_SHORT = DELAY_SHORT_CYC, // Short delay length
    parameter int DLY_LONG = DELAY_LONG_CYC // Long delay length
) (
    input wire logic ref_clk,
    input wire logic nrst,
    input wire logic clkEn,
    input wire logic rstPinIn,
    output logic rstPinOut,
    output logic rstPinOe,
    input wire logic wdgUnderflow,
    input wire logic supplyLowCmp,
    input wire logic auxSupplyLowCmp,
    input wire logic auxExtLowCmp,
    input wire logic optDropEnable,
    input wire logic optLongDelay,
    input wire logic [1:0] optDropLevel,
    input wire logic optCrystalOsc,
    input wire logic irqAck,
    input wire logic [7:0] regAddr,
    input wire logic [7:0] regWdata,
    input wire logic regWr,
    input wire logic regRd,
    output logic [7:0] regRdata,
    output logic cpuRstN,
    output logic vectorFetch,
    output logic [15:0] fetchAddr,
    output logic oscRunEn,
    output logic auxDetEnable,
    output logic auxMonitorSel,
    output logic [1:0] dropLevelSel,
    output logic warnIrq
);

    // ----------------------------------------
    // Declarations
    // ----------------------------------------
    rss_state_e state_reg; // Current phase
    rss_state_e state_next;
    logic extCatch_reg; // Asynchronous pin-low catcher
    logic extMeta_reg; // First synchroniser stage for the catcher
    logic extSync_reg; // Usable external request
    rss_sense_s senseMeta_reg; // First stage for levels
    rss_sense_s sense_reg; // Synchronised levels
    logic [12:0] cnt_reg; // Stretch and delay counter
    logic monitorSelect_reg; // Software select bit
    logic warnIrqEnable_reg; // Software enable bit
    logic dropResetFlag_reg; // Supply-drop reset seen
    logic watchdogResetFlag_reg; // Watchdog reset seen
    logic warnFlag_reg; // Live warning flag
    logic warnPrev_reg; // Flag one cycle ago, for toggle detection
    logic dropLow; // Drop detector request
    logic wdgReq; // Watchdog request while running
    logic resetReq; // Any source demanding the active phase
    logic stretchDone;
    logic delayDone;
    logic warnSet; // Interrupt event this cycle
    logic [12:0] delayLast;
    logic regHit;
    logic [7:0] csrView;

    // Comparator output of the selected warning source
    function automatic logic warnSource(input rss_sense_s s, input logic sel);
        warnSource = sel ? s.auxExtLow : s.auxSupplyLow;
    endfunction

    // ----------------------------------------
    // Pin catcher and synchronisers
    // ----------------------------------------
    // Falling pin edge is caught with no clock at all, so halt mode still resets
    always_ff @(posedge ref_clk or negedge nrst or negedge rstPinIn) begin
        if (!nrst) begin
            extCatch_reg <= 1'b0;
        end else if (!rstPinIn) begin
            extCatch_reg <= 1'b1;
        end else if (clkEn && state_reg != SEQ_RUN) begin
            // Our own drive would re-arm it, so only a running core listens
            extCatch_reg <= 1'b0;
        end
    end

    // Two-stage crossing of the catcher; disarmed outside the run phase
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            extMeta_reg <= 1'b0;
            extSync_reg <= 1'b0;
        end else if (clkEn) begin
            extMeta_reg <= extCatch_reg && state_reg == SEQ_RUN;
            extSync_reg <= extMeta_reg && state_reg == SEQ_RUN;
        end
    end

    // Two-stage crossing of pin and comparator levels
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            senseMeta_reg <= '0;
            sense_reg <= '0;
        end else if (clkEn) begin
            senseMeta_reg <= '{rstPinIn, supplyLowCmp, auxSupplyLowCmp, auxExtLowCmp};
            sense_reg <= senseMeta_reg;
        end
    end

    // ----------------------------------------
    // Reset sources
    // ----------------------------------------
    assign dropLow = optDropEnable && sense_reg.supplyLow;
    assign wdgReq = wdgUnderflow && state_reg == SEQ_RUN;
    assign resetReq = dropLow || wdgReq || extSync_reg;
    assign stretchDone = cnt_reg >= 13'(STRETCH - 1);
    assign delayLast = optLongDelay ? 13'(DLY_LONG - 1) : 13'(DLY_SHORT - 1);
    assign delayDone = cnt_reg == delayLast;

    // ----------------------------------------
    // Sequencer
    // ----------------------------------------
    // Next phase; any source starts the active phase from run, only a drop from delay or fetch
    always_comb begin
        state_next = state_reg;
        unique case (state_reg)
            SEQ_RUN: begin
                if (resetReq) begin
                    state_next = SEQ_ACTIVE;
                end
            end
            SEQ_ACTIVE: begin
                // Leave only when stretched, supply good and pin let go outside
                if (stretchDone && !dropLow && sense_reg.pinHigh) begin
                    state_next = SEQ_DELAY;
                end
            end
            SEQ_DELAY: begin
                if (dropLow) begin
                    state_next = SEQ_ACTIVE;
                end else if (delayDone) begin
                    state_next = SEQ_FETCH;
                end
            end
            SEQ_FETCH: begin
                if (dropLow) begin
                    state_next = SEQ_ACTIVE;
                end else if (cnt_reg == 13'(FETCH_CYC - 1)) begin
                    state_next = SEQ_RUN;
                end
            end
        endcase
    end

    // Phase register; power-on walks the full sequence
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            state_reg <= SEQ_ACTIVE;
        end else if (clkEn) begin
            state_reg <= state_next;
        end
    end

    // Shared counter, cleared at each phase change
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            cnt_reg <= '0;
        end else if (clkEn) begin
            if (state_next != state_reg) begin
                cnt_reg <= '0;
            end else if (state_reg != SEQ_RUN && !(state_reg == SEQ_ACTIVE && stretchDone)) begin
                cnt_reg <= cnt_reg + 13'h0001; // Saturates once stretch is met
            end
        end
    end

    // Pin drive: stretch in active phase, whole delay phase held low
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            rstPinOe <= 1'b1;
            rstPinOut <= 1'b0;
        end else if (clkEn) begin
            rstPinOut <= 1'b0; // Open drain: only ever pulls low
            rstPinOe <= (state_next == SEQ_ACTIVE && (!stretchDone || state_reg != SEQ_ACTIVE
                         || dropLow)) || state_next == SEQ_DELAY;
        end
    end

    // Core side: held in reset until the fetch ends, vector addresses in fetch
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            cpuRstN <= 1'b0;
            vectorFetch <= 1'b0;
            fetchAddr <= VEC_LO_ADDR;
        end else if (clkEn) begin
            cpuRstN <= state_next == SEQ_RUN;
            vectorFetch <= state_next == SEQ_FETCH;
            // Low byte first, then high byte, of the fixed vector
            fetchAddr <= (state_next == SEQ_FETCH && state_reg == SEQ_FETCH)
                         ? VEC_HI_ADDR : VEC_LO_ADDR;
        end
    end

    // Option pass-through; crystals never stop for reset to save start-up time
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            oscRunEn <= 1'b1;
            dropLevelSel <= 2'h0;
            auxDetEnable <= 1'b0;
        end else if (clkEn) begin
            oscRunEn <= optCrystalOsc || state_reg == SEQ_RUN;
            dropLevelSel <= optDropLevel;
            auxDetEnable <= optDropEnable;
        end
    end

    // ----------------------------------------
    // Status flags
    // ----------------------------------------
    assign regHit = regAddr == INTEGRITY_CTRL_STATUS_OFS;

    // Reset cause flags; hardware set beats a software clear in the same cycle
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            dropResetFlag_reg <= 1'b0;
            watchdogResetFlag_reg <= 1'b0;
        end else if (clkEn) begin
            if (dropLow) begin
                dropResetFlag_reg <= 1'b1;
            end else if (regWr && regHit && !regWdata[BIT_DROP_RESET_FLAG]) begin
                dropResetFlag_reg <= 1'b0;
            end
            if (wdgReq) begin
                watchdogResetFlag_reg <= 1'b1;
            end else if (dropLow) begin
                watchdogResetFlag_reg <= 1'b0;
            end else if (regWr && regHit && !regWdata[BIT_WATCHDOG_RESET_FLAG]) begin
                watchdogResetFlag_reg <= 1'b0;
            end
        end
    end

    // Control bits return to zero on every reset of the core
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            monitorSelect_reg <= 1'b0;
            warnIrqEnable_reg <= 1'b0;
        end else if (clkEn) begin
            if (state_reg != SEQ_RUN) begin
                monitorSelect_reg <= 1'b0;
                warnIrqEnable_reg <= 1'b0;
            end else if (regWr && regHit) begin
                monitorSelect_reg <= regWdata[BIT_MONITOR_SELECT];
                warnIrqEnable_reg <= regWdata[BIT_WARN_IRQ_ENABLE];
            end
        end
    end

    // ----------------------------------------
    // Warning detector and its interrupt
    // ----------------------------------------
    // Live flag; writes never touch it, and it is dead without the drop detector
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            warnFlag_reg <= 1'b0;
            warnPrev_reg <= 1'b0;
        end else if (clkEn) begin
            warnFlag_reg <= optDropEnable && warnSource(sense_reg, monitorSelect_reg);
            warnPrev_reg <= warnFlag_reg;
        end
    end

    // Event: a toggle while enabled, or the enabling write itself while the
    // warning stands; the write term must not wait for the enable flop
    assign warnSet = state_reg == SEQ_RUN
                     && ((warnIrqEnable_reg && warnFlag_reg != warnPrev_reg)
                     || (regWr && regHit && regWdata[BIT_WARN_IRQ_ENABLE]
                     && warnFlag_reg));

    // Pending request; a new event in the service cycle is kept
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            warnIrq <= 1'b0;
        end else if (clkEn) begin
            if (warnSet) begin
                warnIrq <= 1'b1;
            end else if (irqAck || !warnIrqEnable_reg || state_reg != SEQ_RUN) begin
                warnIrq <= 1'b0;
            end
        end
    end

    // ----------------------------------------
    // Register read port
    // ----------------------------------------
    always_comb begin
        csrView = REG_RESET_VAL;
        csrView[BIT_MONITOR_SELECT] = monitorSelect_reg;
        csrView[BIT_WARN_IRQ_ENABLE] = warnIrqEnable_reg;
        csrView[BIT_WARN_FLAG] = warnFlag_reg;
        csrView[BIT_DROP_RESET_FLAG] = dropResetFlag_reg;
        csrView[BIT_WATCHDOG_RESET_FLAG] = watchdogResetFlag_reg;
    end

    // Data stands the cycle after the strobe only; unmapped reads zero
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            regRdata <= 8'h00;
        end else if (clkEn) begin
            regRdata <= (regRd && regHit) ? csrView : 8'h00;
        end
    end

    assign auxMonitorSel = monitorSelect_reg;

    // ----------------------------------------
    // Checks
    // ----------------------------------------
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!nrst || !clkEn);

    // Independent count of delay cycles, so the length check does not reuse cnt_reg
    logic [12:0] dlyObs_reg;
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            dlyObs_reg <= '0;
        end else if (clkEn) begin
            dlyObs_reg <= (state_reg == SEQ_DELAY) ? dlyObs_reg + 13'h0001 : 13'h0000;
        end
    end

    sequence seqFetchLo;
        vectorFetch && fetchAddr == VEC_LO_ADDR;
    endsequence
    sequence seqFetchHi;
        vectorFetch && fetchAddr == VEC_HI_ADDR;
    endsequence

    chk_delay_pin_low: assert property (
        state_reg == SEQ_DELAY |-> rstPinOe && !rstPinOut)
        else $error("Pin released during delay phase");
    chk_fetch_two_cycles: assert property (
        $rose(vectorFetch) && !dropLow |-> seqFetchLo ##1 seqFetchHi ##1 (!vectorFetch && cpuRstN))
        else $error("Vector fetch not two cycles");
    chk_phase_order: assert property (
        $rose(state_reg == SEQ_FETCH) |-> $past(state_reg) == SEQ_DELAY)
        else $error("Fetch not preceded by delay");
    chk_delay_length: assert property (
        state_reg == SEQ_DELAY && state_next == SEQ_FETCH |-> dlyObs_reg == delayLast)
        else $error("Stabilisation delay wrong length");
    chk_stretch_min: assert property (
        state_reg == SEQ_ACTIVE && state_next == SEQ_DELAY |-> cnt_reg == 13'(STRETCH - 1))
        else $error("Active phase left before stretch");
    chk_wdg_enters: assert property (
        wdgReq |=> state_reg == SEQ_ACTIVE && rstPinOe && watchdogResetFlag_reg)
        else $error("Watchdog did not start reset");
    chk_drop_static: assert property (
        dropLow |=> state_reg == SEQ_ACTIVE && !cpuRstN ##1 (dropResetFlag_reg && !watchdogResetFlag_reg))
        else $error("Supply drop not held in reset");
    chk_aux_off: assert property (
        !optDropEnable ##1 !optDropEnable |-> !auxDetEnable && !warnFlag_reg)
        else $error("Warning detector active while disabled");
    chk_irq_toggle: assert property (
        state_reg == SEQ_RUN && warnIrqEnable_reg && $changed(warnFlag_reg) |=> warnIrq)
        else $error("Flag toggle raised no interrupt");
    chk_irq_ack: assert property (
        irqAck && !warnSet && warnIrq |=> !warnIrq)
        else $error("Service entry did not clear pending");
    chk_enable_event: assert property (
        state_reg == SEQ_RUN && regWr && regHit && regWdata[BIT_WARN_IRQ_ENABLE] && warnFlag_reg |=> warnIrq)
        else $error("Enabling with flag set raised no interrupt");
    chk_drop_flag_keep: assert property (
        dropResetFlag_reg && !(regWr && regHit && !regWdata[BIT_DROP_RESET_FLAG]) |=> dropResetFlag_reg)
        else $error("Drop flag lost without software clear");

endmodule // rss_reset_supervisor

//--- rtl/rss_pkg.sv
// Constants, types and layouts for the reset sequencer and supply supervisor.
// Assumes one 10 MHz clock and a plain one-word register port.

package rss_pkg;

    // ----------------------------------------
    // Timing
    // ----------------------------------------
    localparam int CLK_PERIOD_NS = 100; // 10 MHz reference clock
    localparam int T_RST_OUT_NS = 20000; // Minimum output pulse width on the pin
    localparam int STRETCH_CYC = (T_RST_OUT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int DELAY_SHORT_CYC = 256; // Short stabilisation delay
    localparam int DELAY_LONG_CYC = 4096; // Long stabilisation delay
    localparam int FETCH_CYC = 2; // Vector fetch phase length

    // ----------------------------------------
    // Vector and register map
    // ----------------------------------------
    localparam logic [15:0] VEC_LO_ADDR = 16'hfffe; // Reset vector, low address
    localparam logic [15:0] VEC_HI_ADDR = 16'hffff; // Reset vector, high address
    localparam logic [7:0] INTEGRITY_CTRL_STATUS_OFS = 8'h00; // Only register
    localparam int BIT_MONITOR_SELECT = 7;
    localparam int BIT_WARN_IRQ_ENABLE = 6;
    localparam int BIT_WARN_FLAG = 5;
    localparam int BIT_DROP_RESET_FLAG = 4;
    localparam int BIT_WATCHDOG_RESET_FLAG = 0;
    localparam logic [7:0] REG_RESET_VAL = 8'h00;

    // Sequencer phases
    typedef enum logic [1:0] {SEQ_RUN, SEQ_ACTIVE, SEQ_DELAY, SEQ_FETCH} rss_state_e;

    // Comparator and pin levels travelling together through the synchroniser
    typedef struct packed {
        logic pinHigh; // Reset pin level
        logic supplyLow; // Drop comparator: supply under threshold
        logic auxSupplyLow; // Warning comparator on main supply
        logic auxExtLow; // Warning comparator on external input
    } rss_sense_s;

endpackage

//--- tb/rss_pin_partner.sv
// Outside circuitry that shares the open-drain reset pin with the device.
// Assumes the device enable is high while the device pulls the pin low.
`timescale 1ns/100ps

module rss_pin_partner (
    input wire logic ref_clk,
    input wire logic rstPinOe,
    output logic rstPinIn
);
    // ----------------------------------------
    // Pin wire
    // ----------------------------------------
    logic extPull = 1'b0; // Outside pull-down active

    // Weak pull-up wins only while nobody pulls low
    assign rstPinIn = !(rstPinOe || extPull);

    // Low pulse of whole cycles, long enough for the catcher and sync
    task automatic pulse(input int n);
        extPull <= 1'b1;
        repeat (n) @(posedge ref_clk);
        extPull <= 1'b0;
    endtask
endmodule // rss_pin_partner

//--- tb/test_reset_sequence_and_voltage_supervisor.sv
// Self-checking bench for the reset sequencer and supply supervisor.
// Assumes the partner model resolves the pin; register reads checked by queue.
`timescale 1ns/100ps

module test_reset_sequence_and_voltage_supervisor import rss_pkg::*;;
    // ----------------------------------------
    // Signals and bookkeeping
    // ----------------------------------------
    localparam int STR = 4; // Short stretch keeps the run brief
    localparam int DS = 8; // Short delay
    localparam int DL = 16; // Long delay, far enough from short
    logic ref_clk, nrst, clkEn, rstPinIn, rstPinOut, rstPinOe, wdgUnderflow;
    logic supplyLowCmp, auxSupplyLowCmp, auxExtLowCmp, optDropEnable, optLongDelay;
    logic optCrystalOsc, irqAck, regWr, regRd, cpuRstN, vectorFetch, oscRunEn;
    logic auxDetEnable, auxMonitorSel, warnIrq, rdSeen, prevCpu;
    logic [1:0] optDropLevel, dropLevelSel;
    logic [7:0] regAddr, regWdata, regRdata, rndAddr;
    logic [15:0] fetchAddr;
    logic [7:0] expRd[$]; // Expected read data, oldest first
    int expSeq[$]; // Expected delay per reset sequence, -1 skips the count
    int n_mismatch = 0;
    int checks_done = 0;
    int seed = 87956;
    int oeCnt, nFetch, e;

    rss_reset_supervisor #(.STRETCH(STR), .DLY_SHORT(DS), .DLY_LONG(DL)) dut (
        .ref_clk(ref_clk), .nrst(nrst), .clkEn(clkEn), .rstPinIn(rstPinIn),
        .rstPinOut(rstPinOut), .rstPinOe(rstPinOe), .wdgUnderflow(wdgUnderflow),
        .supplyLowCmp(supplyLowCmp), .auxSupplyLowCmp(auxSupplyLowCmp),
        .auxExtLowCmp(auxExtLowCmp), .optDropEnable(optDropEnable),
        .optLongDelay(optLongDelay), .optDropLevel(optDropLevel),
        .optCrystalOsc(optCrystalOsc), .irqAck(irqAck), .regAddr(regAddr),
        .regWdata(regWdata), .regWr(regWr), .regRd(regRd), .regRdata(regRdata),
        .cpuRstN(cpuRstN), .vectorFetch(vectorFetch), .fetchAddr(fetchAddr),
        .oscRunEn(oscRunEn), .auxDetEnable(auxDetEnable),
        .auxMonitorSel(auxMonitorSel), .dropLevelSel(dropLevelSel), .warnIrq(warnIrq));
    rss_pin_partner partner (.ref_clk(ref_clk), .rstPinOe(rstPinOe), .rstPinIn(rstPinIn));

    // ----------------------------------------
    // Compare and bus tasks
    // ----------------------------------------
    task automatic cmpv(input logic [15:0] got, input logic [15:0] exp);
        checks_done++;
        if (got !== exp) begin
            n_mismatch++;
            $display("Error at %0t: got %h, expected %h", $time, got, exp);
        end
    endtask
    task automatic cmpRange(input int got, input int lo, input int hi);
        checks_done++;
        if (got < lo || got > hi) begin
            n_mismatch++;
            $display("Error at %0t: count %0d outside %0d..%0d", $time, got, lo, hi);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge ref_clk);
        regAddr <= a;
        regWdata <= d;
        regWr <= 1'b1;
        @(posedge ref_clk);
        regWr <= 1'b0;
    endtask
    // Note first, then strobe; the monitor pops it when data stands
    task automatic rd(input logic [7:0] a, input logic [7:0] exp);
        expRd.push_back(exp);
        @(posedge ref_clk);
        regAddr <= a;
        regRd <= 1'b1;
        @(posedge ref_clk);
        regRd <= 1'b0;
    endtask
    task automatic settle(input int n);
        repeat (n) @(posedge ref_clk);
        @(negedge ref_clk);
    endtask
    task automatic ack();
        @(posedge ref_clk);
        irqAck <= 1'b1;
        @(posedge ref_clk);
        irqAck <= 1'b0;
        settle(1);
    endtask
    // Bounded wait for the core to leave reset
    task automatic wait_run();
        int i;
        for (i = 0; i < 3000 && cpuRstN !== 1'b1; i++) @(negedge ref_clk);
        cmpv(cpuRstN, 1'b1);
    endtask
    task automatic end_of_test();
        $display("Counts: %0d checks, %0d mismatches", checks_done, n_mismatch);
        if (n_mismatch == 0 && checks_done > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    // ----------------------------------------
    // Monitors
    // ----------------------------------------
    initial begin
        ref_clk = 1'b0;
        forever #50 ref_clk = ~ref_clk;
    end
    always @(posedge ref_clk) rdSeen <= regRd;
    // Read data stands one cycle only, zero otherwise
    always @(negedge ref_clk) begin
        if (rdSeen === 1'b1) cmpv(regRdata, expRd.pop_front());
        else if (nrst === 1'b1) cmpv(regRdata, 8'h00);
    end
    // Sequence watcher: pulled cycles and vector fetch per reset
    always @(negedge ref_clk) begin
        if (nrst !== 1'b1) begin
            oeCnt = 0;
            nFetch = 0;
        end else if (cpuRstN === 1'b0) begin
            if (rstPinOe === 1'b1) oeCnt++;
            if (vectorFetch === 1'b1) begin
                cmpv(fetchAddr, (nFetch == 0) ? VEC_LO_ADDR : VEC_HI_ADDR);
                nFetch++;
            end
        end else if (prevCpu === 1'b0) begin
            e = expSeq.pop_front();
            if (e >= 0) cmpRange(oeCnt, STR + e, STR + e + 5);
            cmpRange(nFetch, FETCH_CYC, FETCH_CYC);
            oeCnt = 0;
            nFetch = 0;
        end
        prevCpu = cpuRstN;
    end
    initial begin
        #(100 * 20000);
        n_mismatch++;
        $display("Error at %0t: run did not finish in time", $time);
        end_of_test();
    end

    // ----------------------------------------
    // Main sequence
    // ----------------------------------------
    initial begin
        {nrst, wdgUnderflow, supplyLowCmp, auxSupplyLowCmp, auxExtLowCmp} = '0;
        {optLongDelay, optCrystalOsc, irqAck, regWr, regRd} = '0;
        clkEn = 1'b1;
        optDropEnable = 1'b1;
        optDropLevel = 2'h2;
        regAddr = 8'h00;
        regWdata = 8'h00;
        expSeq.push_back(DS);
        repeat (4) @(posedge ref_clk);
        nrst <= 1'b1;
        wait_run();
        // Register map, reserved and unmapped places
        rd(INTEGRITY_CTRL_STATUS_OFS, REG_RESET_VAL);
        cmpv(dropLevelSel, 2'h2);
        cmpv(auxDetEnable, 1'b1);
        rndAddr = 8'($random(seed)) | 8'h01;
        wr(rndAddr, 8'($random(seed)));
        rd(rndAddr, 8'h00);
        wr(8'h00, 8'h7f);
        rd(8'h00, 8'h40);
        settle(2);
        cmpv(warnIrq, 1'b0);
        $display("Test registers finished");
        // Warning interrupt on enable and on each toggle
        wr(8'h00, 8'h00);
        auxSupplyLowCmp <= 1'b1;
        settle(6);
        cmpv(warnIrq, 1'b0);
        rd(8'h00, 8'h20);
        wr(8'h00, 8'h40);
        settle(2);
        cmpv(warnIrq, 1'b1);
        // Frozen core must not take a service entry
        @(posedge ref_clk);
        clkEn <= 1'b0;
        irqAck <= 1'b1;
        settle(2);
        cmpv(warnIrq, 1'b1);
        @(posedge ref_clk);
        clkEn <= 1'b1;
        irqAck <= 1'b0;
        ack();
        cmpv(warnIrq, 1'b0);
        @(posedge ref_clk);
        auxSupplyLowCmp <= 1'b0;
        settle(6);
        cmpv(warnIrq, 1'b1);
        ack();
        wr(8'h00, 8'h00);
        auxSupplyLowCmp <= 1'b1;
        settle(6);
        @(posedge ref_clk);
        auxSupplyLowCmp <= 1'b0;
        settle(6);
        wr(8'h00, 8'h40);
        settle(3);
        cmpv(warnIrq, 1'b0);
        @(posedge ref_clk);
        auxSupplyLowCmp <= 1'b1;
        settle(6);
        cmpv(warnIrq, 1'b1);
        ack();
        @(posedge ref_clk);
        auxSupplyLowCmp <= 1'b0;
        auxExtLowCmp <= 1'b1;
        wr(8'h00, 8'h80);
        settle(6);
        cmpv(auxMonitorSel, 1'b1);
        rd(8'h00, 8'ha0);
        wr(8'h00, 8'h00);
        auxExtLowCmp <= 1'b0;
        optDropEnable <= 1'b0;
        optDropLevel <= 2'h1;
        auxSupplyLowCmp <= 1'b1;
        settle(6);
        cmpv(auxDetEnable, 1'b0);
        cmpv(dropLevelSel, 2'h1);
        rd(8'h00, 8'h00);
        @(posedge ref_clk);
        optDropEnable <= 1'b1;
        auxSupplyLowCmp <= 1'b0;
        ack();
        $display("Test warning finished");
        // Watchdog, then drop, then long watchdog, then pin pulse
        wr(8'h00, 8'h40);
        wdgUnderflow <= 1'b1;
        optCrystalOsc <= 1'b1;
        expSeq.push_back(DS);
        @(posedge ref_clk);
        wdgUnderflow <= 1'b0;
        settle(3);
        cmpv(rstPinOe, 1'b1);
        cmpv(rstPinOut, 1'b0);
        cmpv(oscRunEn, 1'b1);
        @(posedge ref_clk);
        auxSupplyLowCmp <= 1'b1;
        wait_run();
        settle(2);
        cmpv(warnIrq, 1'b0);
        rd(8'h00, 8'h21);
        @(posedge ref_clk);
        auxSupplyLowCmp <= 1'b0;
        supplyLowCmp <= 1'b1;
        optCrystalOsc <= 1'b0;
        expSeq.push_back(-1);
        settle(6);
        cmpv(oscRunEn, 1'b0);
        settle(20);
        cmpv(rstPinOe, 1'b1);
        cmpv(cpuRstN, 1'b0);
        @(posedge ref_clk);
        supplyLowCmp <= 1'b0;
        wait_run();
        rd(8'h00, 8'h10);
        @(posedge ref_clk);
        optLongDelay <= 1'b1;
        wdgUnderflow <= 1'b1;
        expSeq.push_back(DL);
        @(posedge ref_clk);
        wdgUnderflow <= 1'b0;
        settle(3);
        wait_run();
        rd(8'h00, 8'h11);
        expSeq.push_back(DL);
        @(posedge ref_clk);
        partner.pulse(3);
        settle(4);
        cmpv(cpuRstN, 1'b0);
        wait_run();
        rd(8'h00, 8'h11);
        wr(8'h00, 8'h00);
        rd(8'h00, 8'h00);
        settle(3);
        cmpv(expSeq.size(), 0);
        $display("Test reset sources finished");
        end_of_test();
    end
endmodule // test_reset_sequence_and_voltage_supervisor
